// file: design/sipp_pkg.sv
// Purpose: constants and types shared by the ingress port policy block
// Assumes: 32-bit APB data, register index times four gives the byte address
// Notes:   none
package sipp_pkg;
  // ==========================================================
  // register indices and addresses
  localparam logic [15:0] IDX_TAGGED_ONLY_ADMIT  = 16'h1842;
  localparam logic [15:0] IDX_SPANNING_TREE      = 16'h1843;
  localparam logic [15:0] IDX_PRIORITY_QUEUE_MAP = 16'h1845;
  localparam logic [15:0] IDX_MIRROR_CONFIG      = 16'h1846;
  localparam logic [15:0] IDX_TAG_DIRECTED_TYPE  = 16'h1847;
  localparam logic [15:0] IDX_BROADCAST_THROTTLE = 16'h1848;
  localparam logic [15:0] IDX_INGRESS_CONTROL    = 16'h1850;
  localparam int          ADDR_W                 = 16;
  // ==========================================================
  // writable masks and reset values
  localparam logic [31:0] MASK_ADMIT  = 32'h0000_0007;
  localparam logic [31:0] MASK_STP    = 32'h0000_003F;
  localparam logic [31:0] MASK_PQMAP  = 32'h0000_FFFF;
  localparam logic [31:0] MASK_MIRROR = 32'h0000_01FF;
  localparam logic [31:0] MASK_TDTYPE = 32'h0000_003F;
  localparam logic [31:0] MASK_THROT  = 32'h07FF_FFFF;
  localparam logic [31:0] MASK_CTRL   = 32'h0000_0039;
  localparam logic [31:0] RST_ADMIT   = 32'h0000_0000;
  localparam logic [31:0] RST_STP     = 32'h0000_0000;
  localparam logic [31:0] RST_PQMAP   = 32'h0000_FA41;
  localparam logic [31:0] RST_MIRROR  = 32'h0000_0000;
  localparam logic [31:0] RST_TDTYPE  = 32'h0000_0000;
  localparam logic [31:0] RST_THROT   = 32'h0008_0402;
  localparam logic [31:0] RST_CTRL    = 32'h0000_0038;
  localparam logic [14:0] RST_BUDGET  = 15'h0080;
  // ==========================================================
  // field positions
  localparam int MIR_TX_BIT       = 0;
  localparam int MIR_RX_BIT       = 1;
  localparam int MIR_PORTS_LSB    = 2;
  localparam int MIR_SNIFF_LSB    = 5;
  localparam int MIR_FILT_BIT     = 8;
  localparam int CTRL_VLAN_BIT    = 0;
  localparam int CTRL_LEARN_LSB   = 3;
  localparam int THR_PORT_STRIDE  = 9;
  localparam int THR_EN_OFS       = 8;
  localparam int THR_UNIT_SHIFT   = 6;
  // ==========================================================
  // spanning tree states and timing
  typedef enum logic [1:0] {
    STP_FORWARD  = 2'h0,
    STP_LISTEN   = 2'h1,
    STP_LEARN    = 2'h2,
    STP_DISABLED = 2'h3
  } sipp_stp_t;
  localparam logic [1:0] TAG_DIRECTED_ON = 2'h3;
  localparam int         CLK_PERIOD_NS   = 20;
  localparam int         INTERVAL_NS     = 1720000;
  localparam int         INTERVAL_CYC    = INTERVAL_NS / CLK_PERIOD_NS;
endpackage

// file: design/sipp_thr_if.sv
// Purpose: carrier between policy core and one broadcast throttle unit
// Assumes: single clock domain
// Notes:   none
`timescale 1ns/10ps
`default_nettype none
interface sipp_thr_if;
  logic        tick;
  logic        en;
  logic [7:0]  level;
  logic        req;
  logic [10:0] bytes;
  logic        pass;
  modport core (output tick, output en, output level, output req, output bytes, input pass);
  modport unit (input tick, input en, input level, input req, input bytes, output pass);
endinterface
`default_nettype wire

// file: design/sipp_throttle.sv
// Purpose: per-port broadcast byte budget
// Assumes: req asserted for one cycle per broadcast packet
// Notes:   pass is combinational from budget state
`timescale 1ns/10ps
`default_nettype none
module sipp_throttle
  import sipp_pkg::*;
(
  // clock and reset
  input  wire logic   sys_clk,
  input  wire logic   rst,
  // core side
  sipp_thr_if.unit    thr
);
  logic [14:0] budget_ff;
  logic [14:0] nxt_budget;
  logic [14:0] full_budget;

  // ==========================================================
  // budget
  // level counts 64-byte units
  assign full_budget = 15'(thr.level) << THR_UNIT_SHIFT;
  // a packet is admitted while any budget is left; it may overdraw to zero
  assign thr.pass = !thr.en || (budget_ff != 15'h0000);

  always_comb begin
    nxt_budget = budget_ff;
    if (thr.req && thr.en && budget_ff != 15'h0000) begin
      nxt_budget = (budget_ff > {4'h0, thr.bytes}) ? budget_ff - {4'h0, thr.bytes} : 15'h0000;
    end
    if (thr.tick) begin
      nxt_budget = full_budget;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      budget_ff <= RST_BUDGET;
    end else begin
      budget_ff <= nxt_budget;
    end
  end
endmodule
`default_nettype wire

// file: design/sipp_top.sv
// Purpose: per-port ingress policy registers of a three-port switch engine and their use
// Assumes: one packet descriptor per cycle at most; APB slave for registers
// Notes:   decisions come out one cycle after the descriptor
`timescale 1ns/10ps
`default_nettype none
module sipp_top
  import sipp_pkg::*;
#(
  parameter int NUM_PORTS    = 3,
  parameter int INTERVAL_CNT = INTERVAL_CYC
) (
  // clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [ADDR_W-1:0]     paddr,
  input  wire logic [31:0]           pwdata,
  output logic                       pready,
  output logic [31:0]                prdata,
  output logic                       pslverr,
  // received packet descriptor
  input  wire logic                  pkt_valid,
  input  wire logic [1:0]            pkt_port,
  input  wire logic                  pkt_untagged,
  input  wire logic                  pkt_prio_tagged,
  input  wire logic                  pkt_broadcast,
  input  wire logic [10:0]           pkt_bytes,
  input  wire logic [2:0]            pkt_priority,
  input  wire logic [NUM_PORTS-1:0]  pkt_dest,
  input  wire logic [NUM_PORTS-1:0]  pkt_tag_dest,
  input  wire logic                  pkt_other_drop,
  // decision
  output logic                       res_valid,
  output logic [NUM_PORTS-1:0]       res_dest,
  output logic [1:0]                 res_queue,
  output logic                       res_drop,
  output logic                       res_learn,
  output logic                       res_tag_directed,
  // transmit mirroring
  input  wire logic                  tx_valid,
  input  wire logic [1:0]            tx_port,
  output logic                       tx_mirror_valid,
  output logic [NUM_PORTS-1:0]       tx_mirror_dest
);
  // ==========================================================
  // declarations
  logic [31:0]          admit_ff;
  logic [31:0]          stp_ff;
  logic [31:0]          pqmap_ff;
  logic [31:0]          mirror_ff;
  logic [31:0]          tdtype_ff;
  logic [31:0]          throt_ff;
  logic [31:0]          ctrl_ff;
  logic                 pready_ff;
  logic                 pslverr_ff;
  logic [31:0]          prdata_ff;
  logic [31:0]          rd_word;
  logic                 rd_hit;
  logic [15:0]          reg_idx;
  logic [6:0]           reg_hit;
  logic                 wr_go;
  logic [6:0]           wr_en;
  logic [31:0]          tick_cnt_ff;
  logic                 tick_ff;
  logic [NUM_PORTS-1:0] thr_pass;

  logic                 res_valid_ff;
  logic                 res_drop_ff;
  logic                 res_learn_ff;
  logic                 res_td_ff;
  logic                 txm_valid_ff;
  logic [NUM_PORTS-1:0] res_dest_ff;
  logic [NUM_PORTS-1:0] txm_dest_ff;
  logic [1:0]           res_queue_ff;

  logic                 vlan_on;
  logic                 port_ok;
  logic                 admit_drop;
  logic                 stp_drop;
  logic                 thr_drop;
  logic                 any_drop;
  logic                 mirror_rx;
  logic                 tag_dir;
  logic [1:0]           port_state;
  logic [NUM_PORTS-1:0] sniffer;
  logic [NUM_PORTS-1:0] nxt_dest;

  localparam logic [31:0] TICK_LAST = 32'(INTERVAL_CNT - 1);

  function automatic logic port_bit(input logic [31:0] word, input int lsb, input logic [1:0] port);
    port_bit = word[lsb + int'(port)];
  endfunction

  function automatic logic [1:0] port_pair(input logic [31:0] word, input logic [1:0] port);
    port_pair = word[2*int'(port) +: 2];
  endfunction

  // one decode serves both the read mux and the write enables
  function automatic logic [6:0] reg_sel(input logic [15:0] idx);
    reg_sel = 7'h00;
    case (idx)
      IDX_TAGGED_ONLY_ADMIT:  reg_sel = 7'h01;
      IDX_SPANNING_TREE:      reg_sel = 7'h02;
      IDX_PRIORITY_QUEUE_MAP: reg_sel = 7'h04;
      IDX_MIRROR_CONFIG:      reg_sel = 7'h08;
      IDX_TAG_DIRECTED_TYPE:  reg_sel = 7'h10;
      IDX_BROADCAST_THROTTLE: reg_sel = 7'h20;
      IDX_INGRESS_CONTROL:    reg_sel = 7'h40;
      default:                reg_sel = 7'h00;
    endcase
  endfunction

  // ==========================================================
  // apb slave: no wait state, answer in first access cycle
  assign reg_idx = {2'h0, paddr[ADDR_W-1:2]};
  // misaligned addresses select nothing, so they are refused like unmapped ones
  assign reg_hit = (paddr[1:0] == 2'h0) ? reg_sel(reg_idx) : 7'h00;
  assign wr_go   = psel && penable && pready_ff && pwrite;
  assign wr_en   = wr_go ? reg_hit : 7'h00;
  assign rd_hit  = (reg_hit != 7'h00);
  assign rd_word = ({32{reg_hit[0]}} & admit_ff)
                   | ({32{reg_hit[1]}} & stp_ff)
                   | ({32{reg_hit[2]}} & pqmap_ff)
                   | ({32{reg_hit[3]}} & mirror_ff)
                   | ({32{reg_hit[4]}} & tdtype_ff)
                   | ({32{reg_hit[5]}} & throt_ff)
                   | ({32{reg_hit[6]}} & ctrl_ff);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      pready_ff  <= psel && !penable;
      pslverr_ff <= psel && !penable && !rd_hit;
      if (psel && !penable) begin
        prdata_ff <= rd_word;
      end
    end
  end

  // reserved bits masked on write, so they read back zero
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      admit_ff <= RST_ADMIT;
    end else if (wr_en[0]) begin
      admit_ff <= pwdata & MASK_ADMIT;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stp_ff <= RST_STP;
    end else if (wr_en[1]) begin
      stp_ff <= pwdata & MASK_STP;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pqmap_ff <= RST_PQMAP;
    end else if (wr_en[2]) begin
      pqmap_ff <= pwdata & MASK_PQMAP;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mirror_ff <= RST_MIRROR;
    end else if (wr_en[3]) begin
      mirror_ff <= pwdata & MASK_MIRROR;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tdtype_ff <= RST_TDTYPE;
    end else if (wr_en[4]) begin
      tdtype_ff <= pwdata & MASK_TDTYPE;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      throt_ff <= RST_THROT;
    end else if (wr_en[5]) begin
      throt_ff <= pwdata & MASK_THROT;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl_ff <= RST_CTRL;
    end else if (wr_en[6]) begin
      ctrl_ff <= pwdata & MASK_CTRL;
    end
  end

  // ==========================================================
  // throttle interval timer
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tick_cnt_ff <= 32'h0000_0000;
    end else if (tick_cnt_ff == TICK_LAST) begin
      tick_cnt_ff <= 32'h0000_0000;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 32'h0000_0001;
    end
  end

  // registered, so the refill lands one cycle after the wrap
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= (tick_cnt_ff == TICK_LAST);
    end
  end

  // ==========================================================
  // per-port throttle units
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_thr
    sipp_thr_if thr_bus ();
    assign thr_bus.tick  = tick_ff;
    assign thr_bus.en    = throt_ff[p*THR_PORT_STRIDE + THR_EN_OFS];
    assign thr_bus.level = throt_ff[p*THR_PORT_STRIDE +: 8];
    assign thr_bus.req   = pkt_valid && pkt_broadcast && (pkt_port == 2'(p)) && !admit_drop && !stp_drop;
    assign thr_bus.bytes = pkt_bytes;
    assign thr_pass[p]   = thr_bus.pass;
    sipp_throttle u_thr (
      .sys_clk (sys_clk),
      .rst     (rst),
      .thr     (thr_bus)
    );
  end

  // ==========================================================
  // packet policy
  assign vlan_on    = ctrl_ff[CTRL_VLAN_BIT];
  assign port_state = port_pair(stp_ff, pkt_port);
  assign admit_drop = vlan_on && port_bit(admit_ff, 0, pkt_port)
                      && (pkt_untagged || pkt_prio_tagged);
  // only forwarding passes data; learning state learns but does not forward
  assign stp_drop   = (port_state != STP_FORWARD);
  // port code 3 has no throttle unit; keep its unknown pass out of the decision
  assign port_ok    = (int'(pkt_port) < NUM_PORTS);
  assign thr_drop   = pkt_broadcast && port_ok && !thr_pass[pkt_port];
  assign any_drop   = admit_drop || stp_drop || thr_drop || pkt_other_drop;
  assign sniffer    = mirror_ff[MIR_SNIFF_LSB +: NUM_PORTS];
  assign mirror_rx  = mirror_ff[MIR_RX_BIT] && port_bit(mirror_ff, MIR_PORTS_LSB, pkt_port)
                      && (!any_drop || mirror_ff[MIR_FILT_BIT]);
  assign tag_dir    = (port_pair(tdtype_ff, pkt_port) == TAG_DIRECTED_ON);

  always_comb begin
    nxt_dest = tag_dir ? pkt_tag_dest : pkt_dest;
    if (any_drop) begin
      nxt_dest = '0;
    end
    if (mirror_rx) begin
      nxt_dest = nxt_dest | sniffer;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      res_valid_ff <= 1'b0;
      res_dest_ff  <= '0;
      res_drop_ff  <= 1'b0;
      res_td_ff    <= 1'b0;
    end else begin
      res_valid_ff <= pkt_valid;
      res_dest_ff  <= pkt_valid ? nxt_dest : '0;
      res_drop_ff  <= pkt_valid && any_drop;
      res_td_ff    <= pkt_valid && tag_dir;
    end
  end

  // queue lookup runs every cycle; it only matters beside res_valid
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      res_queue_ff <= 2'h0;
    end else begin
      res_queue_ff <= pqmap_ff[2*pkt_priority +: 2];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      res_learn_ff <= 1'b0;
    end else begin
      res_learn_ff <= pkt_valid && port_bit(ctrl_ff, CTRL_LEARN_LSB, pkt_port)
                      && (port_state == STP_FORWARD || port_state == STP_LEARN);
    end
  end

  // transmit mirroring copy request
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      txm_valid_ff <= 1'b0;
      txm_dest_ff  <= '0;
    end else begin
      txm_valid_ff <= tx_valid && mirror_ff[MIR_TX_BIT] && port_bit(mirror_ff, MIR_PORTS_LSB, tx_port);
      txm_dest_ff  <= sniffer;
    end
  end

  // ==========================================================
  // outputs
  assign pready           = pready_ff;
  assign prdata           = prdata_ff;
  assign pslverr          = pslverr_ff;
  assign res_valid        = res_valid_ff;
  assign res_dest         = res_dest_ff;
  assign res_queue        = res_queue_ff;
  assign res_drop         = res_drop_ff;
  assign res_learn        = res_learn_ff;
  assign res_tag_directed = res_td_ff;
  assign tx_mirror_valid  = txm_valid_ff;
  assign tx_mirror_dest   = txm_dest_ff;
endmodule
`default_nettype wire

// file: verif/sipp_top_properties.sv
// Purpose: port-level properties of the ingress policy block
// Assumes: one clock, rst asynchronous active high
// Notes:   queue map shadowed from apb writes; no packet in a write's cycle
`timescale 1ns/10ps
`default_nettype none
module sipp_top_properties
  import sipp_pkg::*;
#(
  parameter int NUM_PORTS = 3
) (
  // clock and reset
  input wire logic                 sys_clk,
  input wire logic                 rst,
  // apb
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [ADDR_W-1:0]    paddr,
  input wire logic [31:0]          pwdata,
  input wire logic                 pready,
  input wire logic                 pslverr,
  // packets
  input wire logic                 pkt_valid,
  input wire logic [2:0]           pkt_priority,
  input wire logic [NUM_PORTS-1:0] pkt_dest,
  input wire logic [NUM_PORTS-1:0] pkt_tag_dest,
  input wire logic                 pkt_other_drop,
  input wire logic                 res_valid,
  input wire logic [NUM_PORTS-1:0] res_dest,
  input wire logic [1:0]           res_queue,
  input wire logic                 res_drop,
  input wire logic                 res_tag_directed,
  // transmit mirroring
  input wire logic                 tx_valid,
  input wire logic                 tx_mirror_valid
);
  // ==========================================================
  // shadow of the queue map
  logic [15:0] map_ff;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      map_ff <= RST_PQMAP[15:0];
    end else if (psel && penable && pready && pwrite && !pslverr
                 && paddr == {IDX_PRIORITY_QUEUE_MAP[13:0], 2'b00}) begin
      map_ff <= pwdata[15:0];
    end
  end
  // ==========================================================
  // properties
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // past map value is the one the design held when it took the packet
  a_queue_from_map:
    assert property (res_valid |-> res_queue == 2'($past(map_ff) >> (2 * $past(pkt_priority))))
    else $error("egress queue differs from queue map entry");
  a_res_one_later: assert property (res_valid == $past(pkt_valid))
    else $error("decision not one cycle after descriptor");
  a_idle_no_dest: assert property (!res_valid |-> res_dest == '0)
    else $error("destination shown without decision");
  a_other_drop_flag: assert property (pkt_valid && pkt_other_drop |=> res_drop)
    else $error("filtered packet not flagged as drop");
  a_tag_dest_used: assert property (res_valid && !res_drop && res_tag_directed |-> ($past(pkt_tag_dest) & ~res_dest) == '0)
    else $error("tag destination missing");
  a_plain_dest_used: assert property (res_valid && !res_drop && !res_tag_directed |-> ($past(pkt_dest) & ~res_dest) == '0)
    else $error("normal destination missing");
  a_tx_copy_cause: assert property (tx_mirror_valid |-> $past(tx_valid))
    else $error("transmit copy without transmitted packet");
  a_slverr_misalign: assert property (psel && !penable && paddr[1:0] != 2'b00 |=> pready && pslverr)
    else $error("misaligned access not refused");
  a_ready_one_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  c_mirrored_drop: cover property (res_valid && res_drop && res_dest != '0);
  c_tx_copy: cover property (tx_mirror_valid);
  c_tag_directed: cover property (res_valid && res_tag_directed && !res_drop);
endmodule
bind sipp_top sipp_top_properties #(.NUM_PORTS(NUM_PORTS)) u_sipp_top_properties (
  .sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .pkt_valid, .pkt_priority,
  .pkt_dest, .pkt_tag_dest, .pkt_other_drop, .res_valid, .res_dest, .res_queue, .res_drop, .res_tag_directed,
  .tx_valid, .tx_mirror_valid
);
`default_nettype wire

// file: verif/tb_switch_ingress_port_policy_regs.sv
// Purpose: self-checking bench for the ingress policy block
// Assumes: 50 MHz sys_clk, short throttle interval
// Notes:   ordinary packets from a row table, odd cases after it
`timescale 1ns/10ps
`default_nettype none
module tb_switch_ingress_port_policy_regs;
  import sipp_pkg::*;
  // ==========================================================
  // signals and tables
  localparam int INTV = 400;
  typedef struct packed {
    logic [1:0] port;
    logic       un, pt, od;
    logic [2:0] pri, dst, tdst, e_dst;
    logic [1:0] e_q;
    logic       e_dr, e_ln, e_td, e_tx;
  } sipp_row_t;
  logic        sys_clk, rst, psel, penable, pwrite, pready, pslverr, e;
  logic        pkt_valid, pkt_untagged, pkt_prio_tagged, pkt_broadcast, pkt_other_drop;
  logic        res_valid, res_drop, res_learn, res_tag_directed, tx_valid, tx_mirror_valid;
  logic [1:0]  pkt_port, tx_port, res_queue;
  logic [2:0]  pkt_priority, pkt_dest, pkt_tag_dest, res_dest, tx_mirror_dest;
  logic [10:0] pkt_bytes;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, q;
  int          failures, n_checks, cyc;
  sipp_row_t   t;
  sipp_row_t   rows [8] = '{'{0, 0, 0, 0, 0, 6, 0, 6, 1, 0, 1, 0, 0}, '{0, 1, 0, 0, 7, 6, 0, 0, 3, 1, 1, 0, 0},
                            '{0, 0, 1, 0, 4, 6, 0, 0, 2, 1, 1, 0, 0}, '{1, 1, 0, 0, 6, 5, 0, 0, 3, 1, 1, 0, 0},
                            '{2, 1, 0, 0, 1, 3, 2, 3, 0, 0, 1, 1, 1}, '{2, 0, 0, 1, 5, 3, 2, 1, 2, 1, 1, 1, 1},
                            '{1, 0, 0, 0, 2, 1, 0, 0, 0, 1, 1, 0, 0}, '{0, 0, 0, 0, 3, 2, 0, 2, 1, 0, 1, 0, 0}};
  logic [15:0] ridx [7] = '{IDX_TAGGED_ONLY_ADMIT, IDX_SPANNING_TREE, IDX_PRIORITY_QUEUE_MAP, IDX_MIRROR_CONFIG,
                            IDX_TAG_DIRECTED_TYPE, IDX_BROADCAST_THROTTLE, IDX_INGRESS_CONTROL};
  logic [31:0] rrst [7] = '{RST_ADMIT, RST_STP, RST_PQMAP, RST_MIRROR, RST_TDTYPE, RST_THROT, RST_CTRL};
  logic [31:0] rmsk [7] = '{MASK_ADMIT, MASK_STP, MASK_PQMAP, MASK_MIRROR, MASK_TDTYPE, MASK_THROT, MASK_CTRL};
  sipp_top #(.INTERVAL_CNT(INTV)) u_sipp_top (
    .sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .pkt_valid, .pkt_port,
    .pkt_untagged, .pkt_prio_tagged, .pkt_broadcast, .pkt_bytes, .pkt_priority, .pkt_dest, .pkt_tag_dest,
    .pkt_other_drop, .res_valid, .res_dest, .res_queue, .res_drop, .res_learn, .res_tag_directed, .tx_valid,
    .tx_port, .tx_mirror_valid, .tx_mirror_dest
  );
  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      failures++;
      end_sim();
    end
  end
  // ==========================================================
  // tasks
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_checks++;
    if (got !== ex) begin
      failures++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // master waits for pready itself; only the cycle limit ends a hang
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wreg(input logic [15:0] idx, input logic [31:0] d);
    apb(1'b1, {idx[13:0], 2'b00}, d);
  endtask
  task automatic rreg(input logic [15:0] idx, input logic [31:0] ex);
    apb(1'b0, {idx[13:0], 2'b00}, 32'h0);
    chk("prdata", ex, q);
    chk("pslverr", 32'h0, {31'h0, e});
  endtask
  // the same port also reports a transmitted packet, for tx mirroring
  task automatic pkt(input sipp_row_t r, input logic bc, input logic [10:0] nb);
    @(posedge sys_clk);
    {pkt_valid, tx_valid, pkt_port, tx_port, pkt_untagged, pkt_prio_tagged} <= {2'b11, r.port, r.port, r.un, r.pt};
    {pkt_other_drop, pkt_priority, pkt_dest, pkt_tag_dest, pkt_broadcast, pkt_bytes} <= {r.od, r.pri, r.dst, r.tdst, bc, nb};
    @(posedge sys_clk);
    {pkt_valid, tx_valid} <= 2'b00;
    @(negedge sys_clk);
    chk("res_valid", 32'h1, {31'h0, res_valid});
    chk("res_dest", {29'h0, r.e_dst}, {29'h0, res_dest});
    chk("res_queue", {30'h0, r.e_q}, {30'h0, res_queue});
    chk("res_drop", {31'h0, r.e_dr}, {31'h0, res_drop});
    chk("res_learn", {31'h0, r.e_ln}, {31'h0, res_learn});
    if (!r.e_dr) chk("res_tag_directed", {31'h0, r.e_td}, {31'h0, res_tag_directed});
    chk("tx_mirror_valid", {31'h0, r.e_tx}, {31'h0, tx_mirror_valid});
    if (r.e_tx) chk("tx_mirror_dest", 32'h1, {29'h0, tx_mirror_dest});
  endtask
  // ==========================================================
  // main sequence
  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    {psel, penable, pwrite, pkt_valid, pkt_untagged, pkt_prio_tagged, pkt_broadcast, pkt_other_drop, tx_valid} = '0;
    {paddr, pwdata, pkt_port, tx_port, pkt_bytes, pkt_priority, pkt_dest, pkt_tag_dest} = '0;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      rreg(ridx[i], rrst[i]);
      wreg(ridx[i], 32'hFFFF_FFFF);
      rreg(ridx[i], rmsk[i]);
      wreg(ridx[i], rrst[i]);
    end
    apb(1'b0, 16'h6124, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, q);
    apb(1'b1, 16'h6109, 32'h7);
    chk("misaligned err", 32'h1, {31'h0, e});
    rreg(IDX_TAGGED_ONLY_ADMIT, 32'h0);
    wreg(IDX_INGRESS_CONTROL, 32'h39);
    wreg(IDX_TAGGED_ONLY_ADMIT, 32'h1);
    wreg(IDX_SPANNING_TREE, 32'h8);
    wreg(IDX_MIRROR_CONFIG, 32'h133);
    wreg(IDX_TAG_DIRECTED_TYPE, 32'h30);
    foreach (rows[i]) begin
      pkt(rows[i], 1'b0, 11'h40);
    end
    for (int s = 0; s < 4; s++) begin
      wreg(IDX_SPANNING_TREE, 32'(s << 2));
      t = '{1, 0, 0, 0, 0, 1, 0, (s == 0), 1, (s != 0), (s == 0 || s == 2), 0, 0};
      pkt(t, 1'b0, 11'h40);
    end
    wreg(IDX_SPANNING_TREE, 32'h0);
    wreg(IDX_INGRESS_CONTROL, 32'h30);
    t = '{0, 1, 0, 0, 7, 6, 0, 6, 3, 0, 0, 0, 0};
    pkt(t, 1'b0, 11'h40);
    // a budget of 128 lets two 100-byte broadcasts through, then refuses
    wreg(IDX_BROADCAST_THROTTLE, RST_THROT | 32'h100);
    pkt(t, 1'b1, 11'h64);
    pkt(t, 1'b1, 11'h64);
    {t.e_dst, t.e_dr} = {3'h0, 1'b1};
    pkt(t, 1'b1, 11'h64);
    repeat (INTV + 5) @(posedge sys_clk);
    {t.e_dst, t.e_dr} = {3'h6, 1'b0};
    pkt(t, 1'b1, 11'h64);
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    rreg(IDX_MIRROR_CONFIG, RST_MIRROR);
    rreg(IDX_BROADCAST_THROTTLE, RST_THROT);
    end_sim();
  end
endmodule
`default_nettype wire
